// ### design/tpw_three_phase_pwm.sv
/*
 * Three-phase center-based PWM timing unit with APB registers, sync pulse generation,
 * single and double update modes and start-up after the first register writes.
 * Assumes an APB master on sys_clk that honours one wait state per transfer, and synchronous gate driver inputs.
 */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "tpw_defines.svh"

// Contract
// - mode control bit 6 clear selects single update, set selects double update.
// - after reset the update-mode bit is clear, so single update mode.
// - single mode gives one sync per period; its rise loads all timing values.
// - the same sync rise loads the output segment register into output control.
// - double mode adds a midpoint sync which reloads every staged register.
// - status bit 3 reads zero in the first half, one in the second.
// - sync pulse lasts sync width plus one clocks, 1 to 256.
// - sync width register resets to 0x27, forty clocks.
// - sync rate is the switching rate, doubled in double mode; sync leaves the block.
// - each duty gives high-side on-time per half; low side is its adjusted complement.
// - center-based; every edge moves by the dead-time register value, half the dead time, keeping symmetry.
// - single mode high on-time 2(duty-dead), low 2(half-duty-dead).
// - each on-time is clamped between zero and the full period.
// - double mode on-time is the sum of per-half contributions.
// - no output and no counting until half period and three duties are written.
// - first sync comes 1.5 half periods after half-period write, one in double.
// - resolution is two clocks per period in single mode, one in double.
// - the timing unit runs on the instruction-rate clock, one tick per clock.
// - every sync pulse raises an interrupt request to the processor.
// - the 16-bit half-period value counts ticks of half a switching period.
// - dead-time register is 10 bits; dead time is twice its value.
module tpw_three_phase_pwm (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`TPW_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        phase_a_high_out,
    output logic                        phase_a_low_out,
    output logic                        phase_b_high_out,
    output logic                        phase_b_low_out,
    output logic                        phase_c_high_out,
    output logic                        phase_c_low_out,
    output logic                        period_sync_pulse,
    output logic                        sync_irq,
    output logic      [`TPW_SEG_W-1:0]  output_segment_active
);

    // software-facing staging copies
    logic [`TPW_MODE_W-1:0]  mode_control_reg;
    logic [`TPW_HP_W-1:0]    half_period_reg;
    logic [`TPW_DT_W-1:0]    dead_time_reg;
    logic [`TPW_HP_W-1:0]    min_pulse_reg;
    logic [`TPW_SW_W-1:0]    sync_width_reg;
    logic [`TPW_HP_W-1:0]    duty_stage_reg [`TPW_PHASES];
    logic [`TPW_SEG_W-1:0]   output_segment_reg;

    // active copies seen by the timing unit
    logic [`TPW_HP_W-1:0]    half_act_reg;
    logic [`TPW_DT_W-1:0]    dead_act_reg;
    logic [`TPW_HP_W-1:0]    minp_act_reg;
    logic [`TPW_SW_W-1:0]    syncw_act_reg;
    logic [`TPW_HP_W-1:0]    duty_act_reg [`TPW_PHASES];
    logic [`TPW_SEG_W-1:0]   seg_act_reg;

    logic                    half_written_reg;
    logic [`TPW_PHASES-1:0]  duty_written_reg;
    tpw_pkg::tpw_state_type  state_reg;
    logic [17:0]             start_cnt_reg;
    logic [15:0]             cnt_reg;
    logic                    second_half_reg;
    logic                    run_reg;
    logic                    pready_reg;
    logic                    pslverr_reg;
    logic [31:0]             prdata_reg;
    logic                    sync_irq_reg;

    logic                    access;
    logic                    wr_en;
    logic                    addr_hit;
    logic [31:0]             rd_mux;
    logic                    double_mode;
    logic                    all_written;
    logic [17:0]             start_target;
    logic                    boundary;
    logic                    fire;
    logic                    load;
    logic [`TPW_PHASES-1:0]  hi_w;
    logic [`TPW_PHASES-1:0]  lo_w;

    tpw_timing_if tim ();

    assign double_mode = mode_control_reg[`TPW_MODE_DOUBLE_BIT];
    assign all_written = half_written_reg & (&duty_written_reg);

    // APB: one wait state; the write lands on the edge where pready is seen high
    assign access = psel & penable & ~pready_reg;
    assign wr_en  = psel & penable & pready_reg & pwrite & ~pslverr_reg;

    always_comb begin
        addr_hit = 1'b1;
        rd_mux   = 32'h0000_0000;
        case (paddr)
            `TPW_ADDR_MODE:   rd_mux = {24'h00_0000, mode_control_reg};
            `TPW_ADDR_STATUS: begin
                rd_mux[`TPW_STAT_HALF_BIT] = second_half_reg;
                rd_mux[`TPW_STAT_RUN_BIT]  = run_reg;
            end
            `TPW_ADDR_HALF:   rd_mux = {16'h0000, half_period_reg};
            `TPW_ADDR_DEAD:   rd_mux = {22'h00_0000, dead_time_reg};
            `TPW_ADDR_MINP:   rd_mux = {16'h0000, min_pulse_reg};
            `TPW_ADDR_SYNCW:  rd_mux = {24'h00_0000, sync_width_reg};
            `TPW_ADDR_DUTYA:  rd_mux = {16'h0000, duty_stage_reg[0]};
            `TPW_ADDR_DUTYB:  rd_mux = {16'h0000, duty_stage_reg[1]};
            `TPW_ADDR_DUTYC:  rd_mux = {16'h0000, duty_stage_reg[2]};
            `TPW_ADDR_SEG:    rd_mux = {23'h00_0000, output_segment_reg};
            default:          addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= access;
            pslverr_reg <= access & ~addr_hit;
            if (access) begin
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // staging registers: writes never touch the half period in progress
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_control_reg   <= `TPW_MODE_RST;
            half_period_reg    <= `TPW_HP_RST;
            dead_time_reg      <= `TPW_DT_RST;
            min_pulse_reg      <= `TPW_HP_RST;
            sync_width_reg     <= `TPW_SW_RST;
            output_segment_reg <= `TPW_SEG_RST;
        end else if (wr_en) begin
            case (paddr)
                `TPW_ADDR_MODE:  mode_control_reg   <= pwdata[`TPW_MODE_W-1:0];
                `TPW_ADDR_HALF:  half_period_reg    <= pwdata[`TPW_HP_W-1:0];
                `TPW_ADDR_DEAD:  dead_time_reg      <= pwdata[`TPW_DT_W-1:0];
                `TPW_ADDR_MINP:  min_pulse_reg      <= pwdata[`TPW_HP_W-1:0];
                `TPW_ADDR_SYNCW: sync_width_reg     <= pwdata[`TPW_SW_W-1:0];
                `TPW_ADDR_SEG:   output_segment_reg <= pwdata[`TPW_SEG_W-1:0];
                default: ;
            endcase
        end
    end

    generate
        for (genvar p = 0; p < `TPW_PHASES; p++) begin : g_duty
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    duty_stage_reg[p]   <= `TPW_HP_RST;
                    duty_written_reg[p] <= 1'b0;
                    duty_act_reg[p]     <= `TPW_HP_RST;
                end else begin
                    if (wr_en && paddr == `TPW_ADDR_DUTYA + 12'(4 * p)) begin
                        duty_stage_reg[p]   <= pwdata[`TPW_HP_W-1:0];
                        duty_written_reg[p] <= 1'b1;
                    end
                    if (load) begin
                        duty_act_reg[p] <= duty_stage_reg[p];
                    end
                end
            end

            tpw_phase u_phase (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .tim     (tim.sink),
                .duty    (duty_act_reg[p]),
                .hi_out  (hi_w[p]),
                .lo_out  (lo_w[p])
            );
        end
    endgenerate

    // start-up: counting from the first half-period write sets when the first sync comes
    assign start_target = double_mode ? {2'b00, half_period_reg}
                        : {2'b00, half_period_reg} + {3'b000, half_period_reg[15:1]};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_written_reg <= 1'b0;
            state_reg        <= tpw_pkg::TPW_IDLE;
            start_cnt_reg    <= 18'h0_0000;
            run_reg          <= 1'b0;
        end else begin
            if (wr_en && paddr == `TPW_ADDR_HALF) begin
                half_written_reg <= 1'b1;
            end
            case (state_reg)
                tpw_pkg::TPW_IDLE: begin
                    if (wr_en && paddr == `TPW_ADDR_HALF) begin
                        state_reg     <= tpw_pkg::TPW_ARMED;
                        start_cnt_reg <= 18'h0_0001;
                    end
                end
                tpw_pkg::TPW_ARMED: begin
                    if (start_cnt_reg != 18'h3_ffff) begin
                        start_cnt_reg <= start_cnt_reg + 18'h0_0001;
                    end
                    if (fire) begin
                        state_reg <= tpw_pkg::TPW_RUN;
                        run_reg   <= 1'b1;
                    end
                end
                tpw_pkg::TPW_RUN: ;
                default: state_reg <= tpw_pkg::TPW_IDLE;
            endcase
        end
    end

    assign fire = (state_reg == tpw_pkg::TPW_ARMED) && all_written
                  && start_cnt_reg >= start_target;

    // half-period counter, one tick per clock
    assign boundary = run_reg && ({1'b0, cnt_reg} + 17'h0_0001 >= {1'b0, half_act_reg});
    // single mode reloads only when a period starts, double mode at the midpoint too
    assign load = fire || (boundary && (second_half_reg || double_mode));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg         <= 16'h0000;
            second_half_reg <= 1'b0;
        end else if (fire) begin
            cnt_reg         <= 16'h0000;
            second_half_reg <= 1'b0;
        end else if (boundary) begin
            cnt_reg         <= 16'h0000;
            second_half_reg <= ~second_half_reg;
        end else if (run_reg) begin
            cnt_reg         <= cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_act_reg  <= `TPW_HP_RST;
            dead_act_reg  <= `TPW_DT_RST;
            minp_act_reg  <= `TPW_HP_RST;
            syncw_act_reg <= `TPW_SW_RST;
            seg_act_reg   <= `TPW_SEG_RST;
        end else if (load) begin
            half_act_reg  <= half_period_reg;
            dead_act_reg  <= dead_time_reg;
            minp_act_reg  <= min_pulse_reg;
            syncw_act_reg <= sync_width_reg;
            seg_act_reg   <= output_segment_reg;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_irq_reg <= 1'b0;
        end else begin
            sync_irq_reg <= load;
        end
    end

    assign tim.cnt         = cnt_reg;
    assign tim.second_half = second_half_reg;
    assign tim.half_period = half_act_reg;
    assign tim.dead_time   = dead_act_reg;
    assign tim.run         = run_reg;

    // width taken from staging: it is loaded into the active copy on this same edge
    tpw_sync_gen u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .start   (load),
        .width   (sync_width_reg),
        .pulse   (period_sync_pulse)
    );

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign phase_a_high_out      = hi_w[0];
    assign phase_a_low_out       = lo_w[0];
    assign phase_b_high_out      = hi_w[1];
    assign phase_b_low_out       = lo_w[1];
    assign phase_c_high_out      = hi_w[2];
    assign phase_c_low_out       = lo_w[2];
    assign sync_irq              = sync_irq_reg;
    assign output_segment_active = seg_act_reg;

    // helper for the pulse-width check
    logic [8:0] sync_len_reg;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_len_reg <= 9'h000;
        end else if (load) begin
            sync_len_reg <= 9'h001;
        end else if (period_sync_pulse) begin
            sync_len_reg <= sync_len_reg + 9'h001;
        end
    end

    AST_MODE_AFTER_RESET: assert property (@(posedge sys_clk) $fell(sys_rst) |-> !double_mode)
        else $error("update mode not single after reset");
    AST_SYNCW_AFTER_RESET: assert property (@(posedge sys_clk) $fell(sys_rst) |-> sync_width_reg == `TPW_SW_RST)
        else $error("sync width reset value wrong");
    AST_SYNC_WIDTH: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(period_sync_pulse) && !$past(load) |-> $past(sync_len_reg) == {1'b0, syncw_act_reg} + 9'h001)
        else $error("sync pulse width not width plus one");
    AST_SYNC_RISE_LOADS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load |=> period_sync_pulse && half_act_reg == $past(half_period_reg) && dead_act_reg == $past(dead_time_reg))
        else $error("sync rise did not load timing values");
    AST_SEG_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !load |=> $stable(seg_act_reg))
        else $error("output segment changed away from a sync edge");
    AST_HALF_STATUS: assert property (@(posedge sys_clk) disable iff (sys_rst)
        boundary && !fire |=> second_half_reg != $past(second_half_reg))
        else $error("half flag did not toggle at midpoint");
    AST_SINGLE_NO_MID_SYNC: assert property (@(posedge sys_clk) disable iff (sys_rst)
        boundary && !second_half_reg && !double_mode |-> !load)
        else $error("midpoint reload in single update mode");
    AST_IDLE_OUTPUTS_OFF: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !run_reg |=> {hi_w, lo_w} == 6'h00)
        else $error("outputs active before start-up");
    AST_IRQ_WITH_SYNC: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(period_sync_pulse) |-> sync_irq)
        else $error("no interrupt request with sync pulse");

endmodule : tpw_three_phase_pwm

// ### design/tpw_defines.svh
/*
 * Register map, field positions, widths and reset values of the three-phase PWM timing unit.
 * Assumes it is included by its bare name from every file that needs a constant.
 */
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH

`define TPW_ADDR_W          12
`define TPW_ADDR_MODE       12'h000
`define TPW_ADDR_STATUS     12'h004
`define TPW_ADDR_HALF       12'h008
`define TPW_ADDR_DEAD       12'h00c
`define TPW_ADDR_MINP       12'h010
`define TPW_ADDR_SYNCW      12'h014
`define TPW_ADDR_DUTYA      12'h018
`define TPW_ADDR_DUTYB      12'h01c
`define TPW_ADDR_DUTYC      12'h020
`define TPW_ADDR_SEG        12'h024

`define TPW_HP_W            16
`define TPW_DT_W            10
`define TPW_SW_W            8
`define TPW_SEG_W           9
`define TPW_MODE_W          8
`define TPW_PHASES          3

`define TPW_MODE_DOUBLE_BIT 6
`define TPW_STAT_HALF_BIT   3
`define TPW_STAT_RUN_BIT    0

`define TPW_MODE_RST        8'h00
`define TPW_HP_RST          16'h0000
`define TPW_DT_RST          10'h000
`define TPW_SW_RST          8'h27
`define TPW_SEG_RST         9'h000

`endif

// ### design/tpw_pkg.sv
/*
 * Types of the three-phase PWM timing unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tpw_pkg;

    typedef enum logic [1:0] {
        TPW_IDLE,
        TPW_ARMED,
        TPW_RUN
    } tpw_state_type;

endpackage : tpw_pkg

// ### design/tpw_timing_if.sv
/*
 * Timing state shared by the timing unit core and its per-phase comparators.
 * Assumes one clock domain; the core drives, the phases only read.
 */
`timescale 1ns/1ps
interface tpw_timing_if;
    logic [15:0] cnt;
    logic        second_half;
    logic [15:0] half_period;
    logic [9:0]  dead_time;
    logic        run;

    modport source (output cnt, output second_half, output half_period, output dead_time, output run);
    modport sink   (input cnt, input second_half, input half_period, input dead_time, input run);
endinterface : tpw_timing_if

// ### design/tpw_sync_gen.sv
/*
 * Sync pulse stretcher: a start strobe raises the pulse for width plus one clocks.
 * Assumes start is a one-cycle strobe from the same clock domain.
 */
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_sync_gen (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 start,
    input  wire logic [`TPW_SW_W-1:0] width,
    output logic                      pulse
);
    logic [`TPW_SW_W-1:0] left_reg;

    // a new start restarts the pulse, so with an over-long width the pulses of two periods merge into one with no fall between
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse    <= 1'b0;
            left_reg <= '0;
        end else if (start) begin
            pulse    <= 1'b1;
            left_reg <= width;
        end else if (pulse && left_reg != '0) begin
            left_reg <= left_reg - 8'h01;
        end else begin
            pulse    <= 1'b0;
        end
    end
endmodule : tpw_sync_gen

// ### design/tpw_phase.sv
/*
 * One phase of the center-based comparator: high side and dead-time-adjusted low side.
 * Assumes the timing interface counts 0 to half_period-1 in each half.
 */
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_phase (
    input  wire logic                 sys_clk,
    input  wire logic                 sys_rst,
    tpw_timing_if.sink                tim,
    input  wire logic [`TPW_HP_W-1:0] duty,
    output logic                      hi_out,
    output logic                      lo_out
);
    logic signed [17:0] hi_raw;
    logic signed [17:0] lo_raw;
    logic [15:0]        hi_len;
    logic [15:0]        lo_len;
    logic [16:0]        cnt_ext;
    logic               hi_next;
    logic               lo_next;

    function automatic logic [15:0] clamp_len(input logic signed [17:0] raw, input logic [15:0] lim);
        if (raw < 18'sh0) clamp_len = 16'h0000;
        else if (raw > $signed({2'b00, lim})) clamp_len = lim;
        else clamp_len = raw[15:0];
    endfunction : clamp_len

    always_comb begin
        hi_raw  = $signed({2'b00, duty}) - $signed({8'h00, tim.dead_time});
        lo_raw  = $signed({2'b00, tim.half_period}) - $signed({2'b00, duty})
                  - $signed({8'h00, tim.dead_time});
        hi_len  = clamp_len(hi_raw, tim.half_period);
        lo_len  = clamp_len(lo_raw, tim.half_period);
        cnt_ext = {1'b0, tim.cnt};
        // first half: high on-time sits at the end and low at the start, second half the reverse, so each half is
        // resolved to one tick and the high pair is centred on the midpoint
        if (!tim.second_half) begin
            hi_next = cnt_ext + {1'b0, hi_len} >= {1'b0, tim.half_period};
            lo_next = tim.cnt < lo_len;
        end else begin
            hi_next = tim.cnt < hi_len;
            lo_next = cnt_ext + {1'b0, lo_len} >= {1'b0, tim.half_period};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_out <= 1'b0;
            lo_out <= 1'b0;
        end else begin
            hi_out <= tim.run & hi_next;
            lo_out <= tim.run & lo_next;
        end
    end

    AST_NO_SHOOT_THROUGH: assert property (@(posedge sys_clk) disable iff (sys_rst) !(hi_out && lo_out))
        else $error("high and low side of one phase on together");
endmodule : tpw_phase

// ### tb/tpw_drive_model.sv
/*
 * Gate driver and converter side: counts on-cycles of each output, sync spacing and sync width.
 * Assumes synchronous outputs on sys_clk; results refer to whole intervals between sync rises.
 */
`timescale 1ns/1ps
module tpw_drive_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [5:0]  gates,
    input  wire logic        sync_in,
    output logic      [15:0] len_reg,
    output logic      [15:0] width_reg,
    output logic      [15:0] on_reg [6]
);
    logic [15:0] len_cnt, width_cnt;
    logic [15:0] on_cnt [6];
    logic        sync_prev;
    wire         rise = sync_in & ~sync_prev;
    // latches one edge after the rise, so the bench reads two cycles later
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_prev <= 1'b0;
            len_cnt   <= '0;
            width_cnt <= '0;
        end else begin
            sync_prev <= sync_in;
            len_cnt   <= rise ? 16'h0001 : len_cnt + 16'h0001;
            if (rise) len_reg <= len_cnt;
            width_cnt <= sync_in ? width_cnt + 16'h0001 : 16'h0000;
            if (!sync_in && sync_prev) width_reg <= width_cnt;
            for (int i = 0; i < 6; i++) begin
                on_cnt[i] <= rise ? 16'(gates[i]) : on_cnt[i] + 16'(gates[i]);
                if (rise) on_reg[i] <= on_cnt[i];
            end
        end
    end
endmodule : tpw_drive_model

// ### tb/testbench.sv
/*
 * Self-checking bench of the three-phase PWM timing unit, driven over APB.
 * Assumes the register map of tpw_defines.svh and that pready answers within 20 cycles.
 */
`timescale 1ns/1ps
`include "tpw_defines.svh"
module testbench;
    logic                   sys_clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [`TPW_ADDR_W-1:0] paddr = '0;
    logic [31:0]            pwdata = '0, prdata, rd;
    logic                   pready, pslverr, last_err, s1, irq, irq_at;
    logic [5:0]             gates;
    logic                   sync_out;
    logic [`TPW_SEG_W-1:0]  seg_act;
    logic [15:0]            len_m, width_m, h1;
    logic [15:0]            on_m [6];
    logic [15:0]            exp_on [6] = '{16'd0, 16'd60, 16'd32, 16'd20, 16'd40, 16'd12};
    int                     err_total = 0, check_count = 0;
    realtime                t0, t_seen;

    always #2.5 sys_clk = ~sys_clk;

    tpw_three_phase_pwm dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_a_high_out(gates[5]), .phase_a_low_out(gates[4]),
        .phase_b_high_out(gates[3]), .phase_b_low_out(gates[2]), .phase_c_high_out(gates[1]),
        .phase_c_low_out(gates[0]), .period_sync_pulse(sync_out), .sync_irq(irq),
        .output_segment_active(seg_act));

    tpw_drive_model far_side (.sys_clk(sys_clk), .sys_rst(sys_rst), .gates(gates), .sync_in(sync_out),
        .len_reg(len_m), .width_reg(width_m), .on_reg(on_m));

    task final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task check(input logic [31:0] seen, input logic [31:0] expd, input string what);
        check_count++;
        if (seen !== expd) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, expd, seen);
        end
    endtask : check

    // holds the request until pready is seen high at a rising edge
    task apb(input logic wr, input logic [`TPW_ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_total++;
            final_report();
        end
        rd = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_sync;
        int k;
        k = 0;
        while (sync_out === 1'b1 && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        while (sync_out !== 1'b1 && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 400) begin
            err_total++;
            final_report();
        end
        t_seen = $realtime;
        irq_at = irq;
        repeat (2) @(negedge sys_clk);
    endtask : wait_sync

    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `TPW_ADDR_MODE, 32'h0);
        check(rd, 32'h0, "mode after reset");
        apb(1'b0, `TPW_ADDR_SYNCW, 32'h0);
        check(rd, 32'h27, "sync width after reset");
        apb(1'b0, 12'hffc, 32'h0);
        check(rd, 32'h0, "unmapped read data");
        check(last_err, 1'b1, "unmapped error flag");
        $display("reset test done");
        apb(1'b1, `TPW_ADDR_HALF, 32'd30);
        t0 = $realtime;
        apb(1'b1, `TPW_ADDR_DEAD, 32'd2);
        apb(1'b1, `TPW_ADDR_DUTYA, 32'd8);
        apb(1'b1, `TPW_ADDR_DUTYB, 32'd12);
        check({gates, sync_out}, 7'h0, "outputs before start");
        apb(1'b1, `TPW_ADDR_DUTYC, 32'd40);
        wait_sync();
        check(32'($rtoi((t_seen - t0) / 5.0)), 32'd45, "first sync delay");
        check(irq_at, 1'b1, "interrupt with sync");
        // the first period after start is one sample short in the far-side window, so measure a later one
        repeat (2) wait_sync();
        check(len_m, 16'd60, "single period");
        check(width_m, 16'd40, "default sync width");
        for (int i = 0; i < 6; i++) check(on_m[i], exp_on[i], "single on-time");
        apb(1'b1, `TPW_ADDR_SYNCW, 32'h0);
        apb(1'b1, `TPW_ADDR_SEG, 32'h0a7);
        check(seg_act, 9'h000, "segment before sync");
        wait_sync();
        check(seg_act, 9'h0a7, "segment at sync");
        wait_sync();
        check(width_m, 16'd1, "narrow sync width");
        $display("single mode test done");
        apb(1'b1, `TPW_ADDR_MODE, 32'h40);
        apb(1'b0, `TPW_ADDR_MODE, 32'h0);
        check(rd, 32'h40, "mode readback");
        repeat (2) wait_sync();
        check(len_m, 16'd30, "double sync spacing");
        apb(1'b0, `TPW_ADDR_STATUS, 32'h0);
        s1 = ~rd[`TPW_STAT_HALF_BIT];
        wait_sync();
        h1 = on_m[5];
        apb(1'b0, `TPW_ADDR_STATUS, 32'h0);
        check(rd[`TPW_STAT_HALF_BIT], s1, "half flag alternates");
        wait_sync();
        check(h1 + on_m[5], 16'd12, "double on-time sum");
        $display("double mode test done");
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, `TPW_ADDR_MODE, 32'h0);
        check(rd, 32'h0, "mode after restart");
        apb(1'b1, `TPW_ADDR_MODE, 32'h40);
        apb(1'b1, `TPW_ADDR_HALF, 32'd30);
        t0 = $realtime;
        apb(1'b1, `TPW_ADDR_DUTYA, 32'd8);
        apb(1'b1, `TPW_ADDR_DUTYB, 32'd12);
        apb(1'b1, `TPW_ADDR_DUTYC, 32'd40);
        wait_sync();
        check(32'($rtoi((t_seen - t0) / 5.0)), 32'd30, "first sync delay double");
        $display("restart test done");
        final_report();
    end
endmodule : testbench
